// [hw/spicc_pkg.sv]
// spicc_pkg: register map, field positions and reset values of the serial port control block.
// assumes a single clock domain and the plain address/strobe register port.
package spicc_pkg;
   localparam int ADDR_W = 2;
   localparam logic [ADDR_W-1:0] ADDR_CTRL1  = 2'h0;
   localparam logic [ADDR_W-1:0] ADDR_CTRL2  = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h2;
   localparam logic [ADDR_W-1:0] ADDR_DATA   = 2'h3;
   // control one fields
   localparam int C1_RX_IE  = 7;
   localparam int C1_EN     = 6;
   localparam int C1_TX_IE  = 5;
   localparam int C1_MASTER = 4;
   localparam int C1_CLOCK_POLARITY   = 3;
   localparam int C1_CLOCK_PHASE   = 2;
   localparam int C1_SELECT_OUTPUT_ENABLE   = 1;
   localparam int C1_LSBF   = 0;
   // control two fields
   localparam int C2_FDE    = 4;
   localparam int C2_BIDIR  = 3;
   localparam int C2_WSTOP  = 1;
   localparam int C2_SWIRE  = 0;
   // status fields
   localparam int ST_RXF    = 7;
   localparam int ST_TXE    = 5;
   localparam int ST_FAULT  = 4;
   localparam logic [7:0] C1_RST  = 8'h04;
   localparam logic [7:0] C2_RST  = 8'h00;
   localparam logic [7:0] C2_MASK = 8'h1B;
   localparam logic [3:0] LAST_EDGE = 4'hF;
   localparam int HALF_CYC_DEF = 4;
endpackage

// [hw/spicc_core.sv]
// spicc_core: control registers, pin steering and a byte shift engine of a serial peripheral port.
// assumes registers on one clock, pins asynchronous to it, the slave clock far slower than ref_clk_in.
module spicc_core
   import spicc_pkg::*;
#(
   // master miso passes the pin synchroniser: under 3 clocks a half bit samples stale data
   parameter int HALF_CYC = HALF_CYC_DEF
) (
   input  wire logic              ref_clk_in,
   input  wire logic              sys_rst_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [7:0]        wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   output logic      [7:0]        rdata_out,
   output logic                   irq_out,
   input  wire logic              wait_mode_in,
   input  wire logic              sclk_pin_in,
   output logic                   sclk_pin_out,
   output logic                   sclk_pin_oe_out,
   input  wire logic              mosi_pin_in,
   output logic                   mosi_pin_out,
   output logic                   mosi_pin_oe_out,
   input  wire logic              miso_pin_in,
   output logic                   miso_pin_out,
   output logic                   miso_pin_oe_out,
   input  wire logic              ss_n_pin_in,
   output logic                   ss_n_pin_out,
   output logic                   ss_n_pin_oe_out,
   output logic                   ss_release_out
);
   typedef struct packed {
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] rdata;
      logic [7:0] txbuf;
      logic       txf;
      logic [7:0] txsh;
      logic [7:0] rxsh;
      logic [7:0] rxbuf;
      logic       rxf;
      logic       rx_arm;
      logic       tx_arm;
      logic       fault;
      logic       busy;
      logic [3:0] edge_n;
      logic [7:0] div;
      logic       lvl;
      logic       sck1;
      logic       sck2;
      logic       sckp;
      logic       mosi1;
      logic       mosi2;
      logic       miso1;
      logic       miso2;
      logic       ss1;
      logic       ss2;
   } spicc_state_t;

   spicc_state_t q;
   spicc_state_t d;

   logic en, mst, clock_polarity, clock_phase, lsbf, soe, fde, bidir, swire, run, din, dout, edge_hit, sample;

   assign en    = q.c1[C1_EN];
   assign mst   = q.c1[C1_MASTER];
   assign clock_polarity  = q.c1[C1_CLOCK_POLARITY];
   assign clock_phase  = q.c1[C1_CLOCK_PHASE];
   assign lsbf  = q.c1[C1_LSBF];
   assign soe   = q.c1[C1_SELECT_OUTPUT_ENABLE];
   assign fde   = q.c2[C2_FDE];
   assign bidir = q.c2[C2_BIDIR];
   assign swire = q.c2[C2_SWIRE];
   assign run   = en && !(wait_mode_in && q.c2[C2_WSTOP]);
   // single wire: master listens on its data-out pin, slave on its data-out pin
   assign din   = mst ? (swire ? q.mosi2 : q.miso2) : (swire ? q.miso2 : q.mosi2);
   assign dout  = lsbf ? q.txsh[0] : q.txsh[7];
   assign edge_hit = mst ? (q.busy && q.div == 8'(HALF_CYC - 1)) : (q.sck2 != q.sckp && !q.ss2);
   assign sample   = q.edge_n[0] == clock_phase;

   always_comb begin
      d = q;
      d.sck1  = sclk_pin_in;
      d.sck2  = q.sck1;
      d.sckp  = q.sck2;
      d.mosi1 = mosi_pin_in;
      d.mosi2 = q.mosi1;
      d.miso1 = miso_pin_in;
      d.miso2 = q.miso1;
      d.ss1   = ss_n_pin_in;
      d.ss2   = q.ss1;
      d.rdata = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            ADDR_CTRL1: d.rdata = q.c1;
            ADDR_CTRL2: d.rdata = q.c2 & C2_MASK;
            ADDR_STATUS: begin
               d.rdata[ST_RXF]   = q.rxf;
               d.rdata[ST_TXE]   = !q.txf;
               d.rdata[ST_FAULT] = q.fault;
               d.rx_arm = q.rxf;
               d.tx_arm = !q.txf;
            end
            ADDR_DATA: begin
               d.rdata = q.rxbuf;
               if (q.rx_arm) begin
                  d.rxf    = 1'b0;
                  d.rx_arm = 1'b0;
               end
            end
         endcase
      end
      if (wr_in) begin
         unique case (addr_in)
            ADDR_CTRL1: begin
               d.c1    = wdata_in;
               d.fault = 1'b0;
            end
            ADDR_CTRL2: d.c2 = wdata_in & C2_MASK;
            ADDR_STATUS: ;
            ADDR_DATA: begin
               // a write without a prior status read is dropped
               if (q.tx_arm && !q.txf && en) begin
                  d.txbuf  = wdata_in;
                  d.txf    = 1'b1;
                  d.tx_arm = 1'b0;
               end
            end
         endcase
      end
      if (run) begin
         if (!mst && q.ss2)
            d.edge_n = 4'h0;
         if (mst && q.busy)
            d.div = (q.div == 8'(HALF_CYC - 1)) ? 8'h00 : q.div + 8'h01;
         if (edge_hit) begin
            if (sample)
               d.rxsh = lsbf ? {din, q.rxsh[7:1]} : {q.rxsh[6:0], din};
            else if (q.edge_n != 4'h0)
               d.txsh = lsbf ? {1'b0, q.txsh[7:1]} : {q.txsh[6:0], 1'b0};
            d.edge_n = q.edge_n + 4'h1;
            d.lvl    = !q.lvl;
            if (q.edge_n == LAST_EDGE) begin
               d.rxbuf = d.rxsh;
               d.rxf   = 1'b1;
               d.busy  = 1'b0;
            end
         end else if (q.txf && q.edge_n == 4'h0 && !q.busy && !(mst && q.fault)) begin
            // buffer moves to shifter, freeing room for the next byte
            d.txsh = q.txbuf;
            d.txf  = 1'b0;
            d.busy = mst;
            d.div  = 8'h00;
         end
      end
      // fault set after the control write so a live fault is never lost
      if (en && mst && fde && !soe && !q.ss2) begin
         d.fault  = 1'b1;
         d.busy   = 1'b0;
         d.edge_n = 4'h0;
         d.lvl    = 1'b0;
      end
      if (!en) begin
         d.busy   = 1'b0;
         d.edge_n = 4'h0;
         d.div    = 8'h00;
         d.lvl    = 1'b0;
         d.txf    = 1'b0;
         d.rxf    = 1'b0;
         d.rx_arm = 1'b0;
         d.fault  = 1'b0;
         d.txsh   = 8'h00;
         d.rxsh   = 8'h00;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         q    <= '0;
         q.c1 <= C1_RST;
         q.c2 <= C2_RST;
         q.ss1 <= 1'b1;
         q.ss2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rdata_out       = q.rdata;
   assign irq_out         = (q.c1[C1_RX_IE] && (q.rxf || q.fault)) || (q.c1[C1_TX_IE] && !q.txf);
   assign sclk_pin_out    = clock_polarity ^ q.lvl;
   assign sclk_pin_oe_out = en && mst;
   assign mosi_pin_out    = dout;
   assign mosi_pin_oe_out = en && mst && (!swire || bidir);
   assign miso_pin_out    = dout;
   assign miso_pin_oe_out = en && !mst && !q.ss2 && (!swire || bidir);
   assign ss_n_pin_out    = !q.busy;
   assign ss_n_pin_oe_out = en && mst && fde && soe;
   assign ss_release_out  = !en || (mst && !fde);

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_start;
      $rose(q.busy);
   endsequence
   sequence s_done;
      q.busy && edge_hit && q.edge_n == LAST_EDGE && run;
   endsequence

   sequence s_load;
      run && q.txf && !q.busy && q.edge_n == 4'h0 && !edge_hit && !q.fault && !(mst && fde && !soe && !q.ss2);
   endsequence

   AST_RX_IRQ: assert property ($rose(q.rxf) && q.c1[C1_RX_IE] |-> irq_out)
      else $error("receive-full did not raise irq");

   AST_DISABLE: assert property (!en |=> !q.rxf && !q.txf && !q.busy && q.edge_n == 4'h0)
      else $error("disable left state behind");

   AST_OFF_PINS: assert property (!en |-> !sclk_pin_oe_out && !mosi_pin_oe_out && !miso_pin_oe_out
      && !ss_n_pin_oe_out && ss_release_out)
      else $error("disabled port still drives pins");

   AST_TX_IRQ: assert property (q.c1[C1_TX_IE] && !q.txf |-> irq_out)
      else $error("tx empty irq missing");

   AST_NO_IRQ: assert property (q.c1[7:5] == 3'b010 |-> !irq_out)
      else $error("irq raised while masked");

   AST_IDLE_CLK: assert property (s_start |-> sclk_pin_out == clock_polarity)
      else $error("clock left idle level too early");

   AST_FIRST_EDGE: assert property (s_start ##1 (q.busy && !edge_hit)[*1] |-> q.edge_n == 4'h0)
      else $error("edge counted before first half bit");

   AST_DONE_RXF: assert property (s_done |=> q.rxf && !q.busy && sclk_pin_out == clock_polarity)
      else $error("transfer end did not set receive full");

   AST_LOAD_EMPTY: assert property (s_load |=> !q.txf)
      else $error("buffer not freed on load");

   AST_LOAD_BUSY: assert property (s_load ##0 mst |=> q.busy && !ss_n_pin_out)
      else $error("master load did not start transfer");

   AST_SS_FREE: assert property (en && mst && !fde |-> ss_release_out && !ss_n_pin_oe_out)
      else $error("select pin not released");

   AST_FAULT: assert property (en && mst && fde && !soe && !q.ss2 |=> q.fault && !q.busy)
      else $error("mode fault not caught");

   AST_NO_START: assert property (q.fault && mst |=> !$rose(q.busy))
      else $error("transfer started during fault");

   AST_SS_OUT: assert property (ss_n_pin_oe_out |-> ss_n_pin_out == !q.busy)
      else $error("select output wrong");

   AST_SLAVE_SS: assert property (!mst |-> !ss_n_pin_oe_out && !sclk_pin_oe_out)
      else $error("slave drove select or clock");

   AST_UNSELECTED: assert property (en && !mst && q.ss2 |-> !miso_pin_oe_out)
      else $error("unselected slave drove data");

   AST_BIDIR: assert property (en && swire && !bidir |-> !mosi_pin_oe_out && !miso_pin_oe_out)
      else $error("shared pin driven with output off");

   AST_BIDIR_ON: assert property (en && mst && swire && bidir |-> mosi_pin_oe_out)
      else $error("shared pin not driven with output on");

   AST_TWO_PINS: assert property (en && mst && !swire |-> mosi_pin_oe_out)
      else $error("separate data out not driven");

   AST_MASTER_BIDIR_DATA_PIN_ONLY: assert property (en && mst && swire |-> !miso_pin_oe_out)
      else $error("master single wire drove wrong pin");

   AST_SLAVE_BIDIR_DATA_PIN_ONLY: assert property (en && !mst && swire |-> !mosi_pin_oe_out)
      else $error("slave single wire drove wrong pin");

   AST_WAIT_HOLD: assert property (wait_mode_in && q.c2[C2_WSTOP] && en && q.busy
      && !(mst && fde && !soe && !q.ss2) |=> $stable(q.edge_n) && $stable(q.div))
      else $error("engine ran in wait with stop set");

   AST_C1_BACK: assert property (wr_in && addr_in == ADDR_CTRL1 |=> q.c1 == $past(wdata_in))
      else $error("control one did not keep written value");

   AST_C2_ZERO: assert property (rd_in && addr_in == ADDR_CTRL2 |=> rdata_out[7:5] == 3'h0 && !rdata_out[2])
      else $error("unused control bits read nonzero");
endmodule

// [tb/spicc_peer.sv]
// spicc_peer: serial slave on the far side, idle-low clock, samples on rising edges, msb first.
// assumes the select line stays low for the whole byte.
module spicc_peer (
   input  wire logic       sclk_in,
   input  wire logic       mosi_in,
   input  wire logic       ss_n_in,
   input  wire logic [7:0] tx_in,
   output logic            miso_out,
   output logic [7:0]      rx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh_q;
   initial begin
      miso_out = 1'b0;
      rx_out = 8'h00;
      sh_q = 8'h00;
   end
   always @(negedge ss_n_in) begin
      sh_q = tx_in;
      miso_out = tx_in[7];
   end
   // released line must not show a stale bit
   always @(posedge ss_n_in) miso_out = ~miso_out;
   always @(posedge sclk_in) if (!ss_n_in) rx_out = {rx_out[6:0], mosi_in};
   always @(negedge sclk_in) if (!ss_n_in) begin
      sh_q = {sh_q[6:0], 1'b0};
      miso_out = sh_q[7];
   end
endmodule

// [tb/tb.sv]
// tb: register table loop, reset, transfers, abort, fault and pin steering checks.
// assumes spicc_core with default half bit length and spicc_peer as the far slave.
module tb;
   import spicc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [1:0] a; logic [7:0] d; logic [7:0] rd; logic [3:0] pins;} spicc_row_t;
   logic ref_clk_in = 0, sys_rst_in = 1, wr_in = 0, rd_in = 0, wait_mode_in = 0, sclk_pin_in = 0;
   logic mosi_pin_in = 0, ss_drv = 1;
   logic [1:0] addr_in = 0;
   logic [7:0] wdata_in = 0, rdata_out, peer_rx, v;
   logic irq_out, sclk_pin_out, sclk_pin_oe_out, mosi_pin_out, mosi_pin_oe_out, miso_pin_in;
   logic miso_pin_out, miso_pin_oe_out, ss_n_pin_out, ss_n_pin_oe_out, ss_release_out, ss_wire;
   int bad_count = 0, cmp_count = 0;
   // pins = {irq, clock oe, select released, clock level}
   spicc_row_t rows [7] = '{
      '{ADDR_CTRL2, 8'hFF, 8'h1B, 4'h2},
      '{ADDR_CTRL2, 8'h00, 8'h00, 4'h2},
      '{ADDR_CTRL1, 8'h24, 8'h24, 4'hA},
      '{ADDR_CTRL1, 8'h8C, 8'h8C, 4'h3},
      '{ADDR_CTRL1, 8'h54, 8'h54, 4'h6},
      '{ADDR_CTRL1, 8'h4C, 8'h4C, 4'h1},
      '{ADDR_CTRL1, 8'h0C, 8'h0C, 4'h3}};
   assign ss_wire = ss_n_pin_oe_out ? ss_n_pin_out : ss_drv;
   always #20 ref_clk_in = ~ref_clk_in;
   spicc_core u_spicc_core (.ref_clk_in, .sys_rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .irq_out, .wait_mode_in, .sclk_pin_in, .sclk_pin_out, .sclk_pin_oe_out, .mosi_pin_in, .mosi_pin_out,
      .mosi_pin_oe_out, .miso_pin_in, .miso_pin_out, .miso_pin_oe_out, .ss_n_pin_in(ss_wire),
      .ss_n_pin_out, .ss_n_pin_oe_out, .ss_release_out);
   spicc_peer u_spicc_peer (.sclk_in(sclk_pin_out), .mosi_in(mosi_pin_out), .ss_n_in(ss_wire),
      .tx_in(8'hC1), .miso_out(miso_pin_in), .rx_out(peer_rx));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge ref_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      @(negedge ref_clk_in);
      v = rdata_out;
   endtask
   // one byte in master mode; status poll is bounded
   task automatic xfer(input logic [7:0] tx, input logic [7:0] exp_rx, input logic [7:0] exp_peer);
      int n;
      n = 0;
      rd(ADDR_STATUS);
      wr(ADDR_DATA, tx);
      do begin
         rd(ADDR_STATUS);
         n++;
      end while (v[ST_RXF] !== 1'b1 && n < 200);
      rd(ADDR_DATA);
      chk("rx byte", exp_rx, v);
      chk("peer byte", exp_peer, peer_rx);
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk_in);
      bad_count++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk("readback", rows[i].rd, v);
         chk("pins", {4'h0, rows[i].pins}, {4'h0, irq_out, sclk_pin_oe_out, ss_release_out, sclk_pin_out});
      end
      @(posedge ref_clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      rd(ADDR_CTRL1);
      chk("ctrl1 reset", C1_RST, v);
      rd(ADDR_STATUS);
      chk("status reset", 8'h20, v);
      wr(ADDR_CTRL2, 8'h10);
      wr(ADDR_CTRL1, 8'h52);
      @(negedge ref_clk_in);
      chk("select oe", 8'h01, {7'h0, ss_n_pin_oe_out});
      xfer(8'hA5, 8'hC1, 8'hA5);
      wr(ADDR_CTRL1, 8'h53);
      xfer(8'h1E, 8'h83, 8'h78);
      rd(ADDR_STATUS);
      wr(ADDR_DATA, 8'h5A);
      repeat (10) @(posedge ref_clk_in);
      wr(ADDR_CTRL1, 8'h12);
      rd(ADDR_STATUS);
      chk("status after abort", 8'h20, v);
      wr(ADDR_CTRL1, 8'hD0);
      ss_drv <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      rd(ADDR_STATUS);
      chk("fault status", 8'h30, v);
      chk("fault irq", 8'h01, {7'h0, irq_out});
      @(posedge ref_clk_in);
      ss_drv <= 1'b1;
      wr(ADDR_CTRL1, 8'h10);
      wr(ADDR_CTRL1, 8'h50);
      wr(ADDR_CTRL2, 8'h19);
      @(negedge ref_clk_in);
      chk("bidir on", 8'h02, {6'h0, mosi_pin_oe_out, miso_pin_oe_out});
      wr(ADDR_CTRL2, 8'h11);
      @(negedge ref_clk_in);
      chk("bidir off", 8'h00, {6'h0, mosi_pin_oe_out, miso_pin_oe_out});
      wr(ADDR_CTRL2, 8'h18);
      @(negedge ref_clk_in);
      chk("two pins", 8'h02, {6'h0, mosi_pin_oe_out, miso_pin_oe_out});
      // wait with clock stop: a queued byte must not start until wait ends
      wr(ADDR_CTRL1, 8'h52);
      wr(ADDR_CTRL2, 8'h12);
      wait_mode_in <= 1'b1;
      rd(ADDR_STATUS);
      wr(ADDR_DATA, 8'h3C);
      repeat (40) @(posedge ref_clk_in);
      rd(ADDR_STATUS);
      chk("status in wait", 8'h00, v);
      @(posedge ref_clk_in);
      wait_mode_in <= 1'b0;
      repeat (120) @(posedge ref_clk_in);
      rd(ADDR_STATUS);
      chk("status after wait", 8'hA0, v);
      chk("peer after wait", 8'h3C, peer_rx);
      print_verdict();
   end
endmodule
